// File: smb_pkg.sv
// Shared constants, states and carriers of the SMBus mailbox
package smb_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int MST_SCL_NS = 10000;
  localparam int MST_QTR_CYC = MST_SCL_NS / (4 * CLK_NS);
  localparam int BUS_FREE_NS = 4700;
  localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_SLV_ADDR = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h02C;
  localparam logic [11:0] OFS_MST_CTRL = 12'h030;
  localparam logic [11:0] OFS_REGFILE = 12'h100;
  localparam logic [11:0] OFS_PKTBUF = 12'h200;
  localparam int RF_WORDS = 16;
  localparam logic [6:0] SLV_ADDR_RST = 7'h2A;
  localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;
  localparam int CTL_DATSRC_BIT = 5;
  localparam int CTL_ALERT_BIT = 6;
  localparam int ST_RXEMPTY_BIT = 0;
  localparam int ST_TXEMPTY_BIT = 3;
  localparam int ST_TXFULL_BIT = 5;
  localparam int ST_MBUSY_BIT = 8;
  localparam int ST_ARBLOST_BIT = 9;
  localparam int ST_NACK_BIT = 10;
  localparam int ST_MDONE_BIT = 11;
  localparam int MCTL_START_BIT = 31;
  localparam int MCTP_HDR_BYTES = 8;
  localparam logic [7:0] MCTP_MIN_LEN = 8'(MCTP_HDR_BYTES - 3);
  localparam logic [7:0] MCTP_MAX_LEN = 8'(RF_WORDS);
  // ****************************************
  // AHB-Lite transfer types
  // ****************************************
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_BUSY = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  // ****************************************
  // States and carriers
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_ADACK = 3'b010, S_RX = 3'b011,
    S_RXACK = 3'b100, S_TX = 3'b101, S_TXACK = 3'b110
  } smb_slv_state_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_FAIR = 3'b001, M_START = 3'b010, M_XFER = 3'b011, M_STOP = 3'b100
  } smb_mst_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic mapped;
  } smb_ahb_req_t;
  typedef struct packed {
    logic [6:0] dest;
    logic [7:0] cmd;
    logic [7:0] len;
  } smb_mst_cfg_t;
endpackage : smb_pkg

// File: smb_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module smb_sync2 #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] metaQ;

  initial begin
    if (W < 1) $error("smb_sync2: W must be at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      metaQ <= '1;
      syncOut <= '1;
    end else begin
      metaQ <= asyncIn;
      syncOut <= metaQ;
    end
  end
endmodule : smb_sync2

// File: smb_two_buf.sv
// Small valid/ready FIFO used on the receive and transmit byte paths
`timescale 1ns/10ps
module smb_two_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wrPtrQ;
  logic [AW:0] rdPtrQ;
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("smb_two_buf: DEPTH must be a power of two >= 2");
  end

  assign inReady = (wrPtrQ[AW] == rdPtrQ[AW]) || (wrPtrQ[AW-1:0] != rdPtrQ[AW-1:0]);
  assign outValid = wrPtrQ != rdPtrQ;
  assign outData = mem[rdPtrQ[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (doWr) mem[wrPtrQ[AW-1:0]] <= inData;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
    end else begin
      if (doWr) wrPtrQ <= wrPtrQ + 1'b1;
      if (doRd) rdPtrQ <= rdPtrQ + 1'b1;
    end
  end
endmodule : smb_two_buf

// File: smb_mailbox_top.sv
// SMBus mailbox: AHB-Lite slave, slave and master controllers, pin switch
`timescale 1ns/10ps
module smb_mailbox_top
  import smb_pkg::*;
#(
  parameter int QTR_CYC = MST_QTR_CYC,
  parameter int FREE_CYC = BUS_FREE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic host_bus_port_hsel,
  input wire logic [31:0] host_bus_port_haddr,
  input wire logic [2:0] host_bus_port_hburst,
  input wire logic [2:0] host_bus_port_hsize,
  input wire logic [1:0] host_bus_port_htrans,
  input wire logic [31:0] host_bus_port_hwdata,
  input wire logic host_bus_port_hwrite,
  input wire logic host_bus_port_hready,
  output logic host_bus_port_hreadyout,
  output logic host_bus_port_hresp,
  output logic [31:0] host_bus_port_hrdata,
  output logic intReq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic smbAlert_n
);
  initial begin
    if (QTR_CYC < 2 || QTR_CYC > 65536 || FREE_CYC < 1 || FREE_CYC > 65536)
      $error("smb_mailbox_top: timing counts outside the 16-bit counters");
  end

  // ****************************************
  // Pin sampling
  // ****************************************
  logic [1:0] pinSync;
  logic sclP, sdaP, busyQ;
  smb_sync2 #(.W(2)) uSync (
    .clk_sys(clk_sys), .rst_n(rst_n), .asyncIn({scl_i, sda_i}), .syncOut(pinSync)
  );
  wire sclS = pinSync[1];
  wire sdaS = pinSync[0];
  wire sclRise = sclS && !sclP;
  wire sclFall = !sclS && sclP;
  wire startDet = sclS && sclP && sdaP && !sdaS;
  wire stopDet = sclS && sclP && !sdaP && sdaS;

  // ****************************************
  // Host port decode
  // ****************************************
  function automatic logic inRange(input logic [11:0] a, input logic [11:0] base);
    inRange = a[11:6] == base[11:6];
  endfunction

  wire [11:0] apAddr = {host_bus_port_haddr[11:2], 2'b00};
  // Every beat, burst or not, is a plain word access at its own address
  wire apValid = host_bus_port_hsel && host_bus_port_hready && host_bus_port_htrans[1];
  wire apMapped = apAddr == OFS_DATA || apAddr == OFS_SLV_ADDR || apAddr == OFS_CONTROL
                  || apAddr == OFS_STATUS || apAddr == OFS_MST_CTRL
                  || inRange(apAddr, OFS_REGFILE) || inRange(apAddr, OFS_PKTBUF);
  smb_ahb_req_t dpQ;
  logic dpValidQ, dpErrQ, readyQ, respQ;
  logic [31:0] rdataQ;
  wire dpWr = dpValidQ && dpQ.write && dpQ.mapped;
  wire dpRd = dpValidQ && !dpQ.write && dpQ.mapped;
  wire [3:0] dpIdx = dpQ.addr[5:2];
  wire [31:0] wd = host_bus_port_hwdata;

  // ****************************************
  // Host registers
  // ****************************************
  logic [6:0] slvAddrQ;
  logic [31:0] ctrlQ;
  logic [RF_WORDS-1:0][7:0] regFileQ;
  logic [7:0] pktBufQ [RF_WORDS];
  smb_mst_cfg_t mCfgQ;
  logic arbLostQ, nackQ, mDoneQ;
  wire rfWrEn = dpWr && inRange(dpQ.addr, OFS_REGFILE);
  wire mStartReq = dpWr && dpQ.addr == OFS_MST_CTRL && wd[MCTL_START_BIT];
  wire dataSrcReg = ctrlQ[CTL_DATSRC_BIT];

  // Byte paths through the two-entry buffers
  logic rxInValid, rxInReady, rxOutValid, txInReady, txOutValid, txLoad;
  logic [7:0] rxOutData, txOutData, sShiftQ;
  wire rxPop = dpRd && dpQ.addr == OFS_DATA;
  wire txPush = dpWr && dpQ.addr == OFS_DATA;
  smb_two_buf #(.W(8), .DEPTH(2)) uRxBuf (
    .clk_sys(clk_sys), .rst_n(rst_n), .inValid(rxInValid), .inReady(rxInReady),
    .inData(sShiftQ), .outValid(rxOutValid), .outReady(rxPop), .outData(rxOutData)
  );
  smb_two_buf #(.W(8), .DEPTH(2)) uTxBuf (
    .clk_sys(clk_sys), .rst_n(rst_n), .inValid(txPush), .inReady(txInReady),
    .inData(wd[7:0]), .outValid(txOutValid), .outReady(txLoad && !dataSrcReg),
    .outData(txOutData)
  );

  smb_mst_state_t mStateQ, mStateD;
  wire mBusy = mStateQ != M_IDLE;
  wire [31:0] statusWord = {20'h0, mDoneQ, nackQ, arbLostQ, mBusy, 2'h0, !txInReady,
                            1'b0, !txOutValid, 2'h0, !rxOutValid};
  wire [31:0] rdMux =
    dpQ.addr == OFS_DATA ? {24'h0, rxOutValid ? rxOutData : 8'h00} :
    dpQ.addr == OFS_SLV_ADDR ? {25'h0, slvAddrQ} :
    dpQ.addr == OFS_CONTROL ? ctrlQ :
    dpQ.addr == OFS_STATUS ? statusWord :
    dpQ.addr == OFS_MST_CTRL ? {8'h0, mCfgQ.len, mCfgQ.cmd, 1'b0, mCfgQ.dest} :
    inRange(dpQ.addr, OFS_REGFILE) ? {24'h0, regFileQ[dpIdx]} : {24'h0, pktBufQ[dpIdx]};

  // ****************************************
  // Host bus response
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dpQ <= '0;
      dpValidQ <= 1'b0;
      dpErrQ <= 1'b0;
      readyQ <= 1'b1;
      respQ <= 1'b0;
      rdataQ <= 32'h0;
    end else begin
      dpValidQ <= apValid;
      dpQ <= '{addr: apAddr, write: host_bus_port_hwrite, mapped: apMapped};
      dpErrQ <= apValid && !apMapped;
      // Reads take one wait state, errors take the two-cycle response
      readyQ <= !(apValid && !(host_bus_port_hwrite && apMapped));
      respQ <= (apValid && !apMapped) || dpErrQ;
      if (dpRd) rdataQ <= rdMux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slvAddrQ <= SLV_ADDR_RST;
      ctrlQ <= 32'h0;
      regFileQ <= '0;
    end else begin
      if (dpWr && dpQ.addr == OFS_SLV_ADDR) slvAddrQ <= wd[6:0];
      if (dpWr && dpQ.addr == OFS_CONTROL) ctrlQ <= wd;
      if (rfWrEn) regFileQ[dpIdx] <= wd[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dpWr && inRange(dpQ.addr, OFS_PKTBUF)) pktBufQ[dpIdx] <= wd[7:0];
  end

  // ****************************************
  // Slave controller
  // ****************************************
  smb_slv_state_t sStateQ, sStateD;
  logic [3:0] sBitQ, sBitD, sCmdQ, sCmdD;
  logic [7:0] sShiftD;
  logic sSdaQ, sSdaD, sFirstQ, sFirstD, sFlagQ, sFlagD;
  wire addrHit = sShiftQ[7:1] == slvAddrQ || sShiftQ[7:1] == SMB_DEFAULT_ADDR;
  wire [7:0] txByte = dataSrcReg ? regFileQ[sCmdQ] : (txOutValid ? txOutData : 8'hFF);

  always_comb begin
    sStateD = sStateQ;
    sBitD = sBitQ;
    sShiftD = sShiftQ;
    sSdaD = sSdaQ;
    sCmdD = sCmdQ;
    sFirstD = sFirstQ;
    sFlagD = sFlagQ;
    rxInValid = 1'b0;
    txLoad = 1'b0;
    if (startDet) begin // Repeated start keeps the command for Read Byte
      sStateD = S_ADDR;
      sBitD = 4'h0;
      sSdaD = 1'b0;
    end else if (stopDet) begin
      sStateD = S_IDLE;
      sSdaD = 1'b0;
    end else begin
      case (sStateQ)
        S_ADDR, S_RX: begin
          if (sclRise && sBitQ != 4'h8) begin
            sShiftD = {sShiftQ[6:0], sdaS};
            sBitD = sBitQ + 4'h1;
          end else if (sclFall && sBitQ == 4'h8) begin
            if (sStateQ == S_ADDR) begin
              sSdaD = addrHit;
              sFlagD = sShiftQ[0];
              sStateD = addrHit ? S_ADACK : S_IDLE;
            end else begin
              rxInValid = 1'b1;
              sSdaD = rxInReady;
              if (sFirstQ && rxInReady) sCmdD = sShiftQ[3:0];
              if (rxInReady) sFirstD = 1'b0;
              sStateD = S_RXACK;
            end
          end
        end
        S_ADACK, S_RXACK: begin
          if (sclFall) begin
            sBitD = 4'h0;
            if (sStateQ == S_ADACK && sFlagQ) begin
              txLoad = 1'b1;
              sShiftD = txByte;
              sSdaD = !txByte[7];
              sStateD = S_TX;
            end else begin
              sSdaD = 1'b0;
              if (sStateQ == S_ADACK) sFirstD = 1'b1;
              sStateD = S_RX;
            end
          end
        end
        S_TX: begin
          if (sclFall && sBitQ == 4'h7) begin
            sSdaD = 1'b0;
            sStateD = S_TXACK;
          end else if (sclFall) begin
            sShiftD = {sShiftQ[6:0], 1'b0};
            sSdaD = !sShiftQ[6];
            sBitD = sBitQ + 4'h1;
          end
        end
        S_TXACK: begin
          if (sclRise) begin
            sFlagD = !sdaS;
          end else if (sclFall && sFlagQ) begin
            txLoad = 1'b1;
            sShiftD = txByte;
            sSdaD = !txByte[7];
            sBitD = 4'h0;
            sStateD = S_TX;
          end else if (sclFall) begin
            sStateD = S_IDLE;
          end
        end
        default: sStateD = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sStateQ <= S_IDLE;
      {sBitQ, sCmdQ, sShiftQ} <= 16'h0;
      {sSdaQ, sFirstQ, sFlagQ} <= 3'h0;
      {sclP, sdaP, busyQ} <= 3'b110;
    end else begin
      sStateQ <= sStateD;
      {sBitQ, sCmdQ, sShiftQ} <= {sBitD, sCmdD, sShiftD};
      {sSdaQ, sFirstQ, sFlagQ} <= {sSdaD, sFirstD, sFlagD};
      {sclP, sdaP} <= {sclS, sdaS};
      busyQ <= startDet || (busyQ && !stopDet);
    end
  end

  // ****************************************
  // Master controller
  // ****************************************
  logic [15:0] mCntQ;
  logic [15:0] idleCntQ;
  logic [1:0] mPhQ;
  logic [3:0] mBitQ;
  logic [7:0] mIdxQ;
  logic mSdaQ, mSclQ;
  wire mOwn = mStateQ == M_START || mStateQ == M_XFER || mStateQ == M_STOP;
  wire mTick = mCntQ == 16'(QTR_CYC - 1);
  wire mHold = mPhQ == 2'h2 && !sclS && mStateQ != M_START;
  wire mLast = mIdxQ == mCfgQ.len + 8'h2;
  wire [7:0] mByte = mIdxQ == 8'h0 ? {mCfgQ.dest, 1'b0} : mIdxQ == 8'h1 ? mCfgQ.cmd :
                     mIdxQ == 8'h2 ? mCfgQ.len : pktBufQ[4'(mIdxQ - 8'h3)];
  wire mLose = mStateQ == M_XFER && mTick && mPhQ == 2'h2 && mBitQ != 4'h8 && !mSdaQ && !sdaS;
  wire mNack = mStateQ == M_XFER && mTick && mPhQ == 2'h2 && mBitQ == 4'h8 && sdaS;

  always_comb begin
    mStateD = mStateQ;
    case (mStateQ)
      M_IDLE: if (mStartReq) mStateD = M_FAIR;
      M_FAIR: if (idleCntQ == 16'(FREE_CYC - 1) && !busyQ) mStateD = M_START;
      M_START: if (mTick && mPhQ == 2'h1) mStateD = M_XFER;
      M_XFER: begin
        if (mLose) mStateD = M_FAIR;
        else if (mTick && mPhQ == 2'h3 && mBitQ == 4'h8 && (nackQ || mLast)) mStateD = M_STOP;
      end
      M_STOP: if (mTick && mPhQ == 2'h2) mStateD = M_IDLE;
      default: mStateD = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mStateQ <= M_IDLE;
      {mCntQ, idleCntQ} <= 32'h0;
      {mPhQ, mBitQ, mIdxQ} <= 14'h0;
      {mSdaQ, mSclQ} <= 2'h0;
    end else begin
      mStateQ <= mStateD;
      mCntQ <= (mTick || !mOwn || mHold) ? 16'h0 : mCntQ + 16'h1;
      idleCntQ <= (mStateQ != M_FAIR || busyQ || !sclS || !sdaS) ? 16'h0 : idleCntQ + 16'h1;
      if (mStateD == M_FAIR) begin
        {mPhQ, mBitQ, mIdxQ} <= 14'h0;
        {mSdaQ, mSclQ} <= 2'h0;
      end else if (mOwn && mTick) begin
        mPhQ <= (mStateQ == M_START && mPhQ == 2'h1) ? 2'h0 : mPhQ + 2'h1;
        if (mStateQ == M_START) begin
          if (mPhQ == 2'h0) mSdaQ <= 1'b1;
          else mSclQ <= 1'b1;
        end else if (mStateQ == M_STOP) begin
          if (mPhQ == 2'h0) mSdaQ <= 1'b1;
          if (mPhQ == 2'h1) mSclQ <= 1'b0;
          if (mPhQ == 2'h2) mSdaQ <= 1'b0;
        end else if (mPhQ == 2'h0) begin
          mSdaQ <= mBitQ != 4'h8 && !mByte[3'(4'h7 - mBitQ)];
        end else if (mPhQ == 2'h1) begin
          mSclQ <= 1'b0;
        end else if (mPhQ == 2'h3) begin
          mSclQ <= 1'b1;
          mBitQ <= mBitQ == 4'h8 ? 4'h0 : mBitQ + 4'h1;
          if (mBitQ == 4'h8) mIdxQ <= mIdxQ + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mCfgQ <= '0;
      {arbLostQ, nackQ, mDoneQ} <= 3'h0;
    end else begin
      if (mStartReq && !mBusy) begin
        mCfgQ <= '{dest: wd[6:0], cmd: wd[15:8],
                   len: wd[23:16] < MCTP_MIN_LEN ? MCTP_MIN_LEN :
                        wd[23:16] > MCTP_MAX_LEN ? MCTP_MAX_LEN : wd[23:16]};
      end
      // Hardware events win over the clear made by a new start
      arbLostQ <= mLose || (arbLostQ && !mStartReq);
      nackQ <= mNack || (nackQ && !mStartReq && mStateQ != M_FAIR);
      mDoneQ <= (mStateQ == M_STOP && mStateD == M_IDLE) || (mDoneQ && !mStartReq);
    end
  end

  // ****************************************
  // Pin switch and registered outputs
  // ****************************************
  logic sclOeQ, sdaOeQ, pinLevelQ, intQ, alertNQ;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {sclOeQ, sdaOeQ, pinLevelQ, intQ} <= 4'h0;
      alertNQ <= 1'b1;
    end else begin
      sclOeQ <= mOwn && mSclQ;
      sdaOeQ <= mOwn ? mSdaQ : sSdaQ;
      intQ <= rxOutValid || mDoneQ || arbLostQ || nackQ;
      alertNQ <= !ctrlQ[CTL_ALERT_BIT];
    end
  end
  assign scl_oe = sclOeQ;
  assign sda_oe = sdaOeQ;
  assign scl_o = pinLevelQ;
  assign sda_o = pinLevelQ;
  assign intReq = intQ;
  assign smbAlert_n = alertNQ;
  assign host_bus_port_hreadyout = readyQ;
  assign host_bus_port_hresp = respQ;
  assign host_bus_port_hrdata = rdataQ;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_switch_slave: assert property (!mOwn |=> !sclOeQ && sdaOeQ == $past(sSdaQ))
    else $error("slave path not on pins while master idle");
  a_switch_master: assert property (mOwn |=> sdaOeQ == $past(mSdaQ) && sclOeQ == $past(mSclQ))
    else $error("master path not on pins while master runs");
  a_fair_start: assert property ($rose(mStateQ == M_START) |-> $past(idleCntQ) == 16'(FREE_CYC - 1) && !$past(busyQ))
    else $error("master started without bus free time");
  a_rx_store: assert property (sStateQ == S_RX && sclFall && sBitQ == 4'h8 && !startDet
    && !stopDet |-> rxInValid ##1 rxOutValid)
    else $error("received byte not offered to receive buffer");
  a_src_select: assert property (txLoad && dataSrcReg |=> sShiftQ == $past(regFileQ[sCmdQ]))
    else $error("read byte not from register file");
  a_rf_host_only: assert property (!rfWrEn |=> $stable(regFileQ))
    else $error("register file changed without host write");
  a_default_addr: assert property (sStateQ == S_ADDR && sclFall && sBitQ == 4'h8 && sShiftQ[7:1] == SMB_DEFAULT_ADDR && !startDet && !stopDet |=> sStateQ == S_ADACK ##1 sSdaQ)
    else $error("default address not acknowledged");
  a_no_access: assert property (!(host_bus_port_hsel && host_bus_port_hready && host_bus_port_htrans[1]) |=> !dpValidQ)
    else $error("register access without valid transfer");
  a_read_wait: assert property (apValid && !host_bus_port_hwrite && apMapped |=> !host_bus_port_hreadyout ##1 host_bus_port_hreadyout && !host_bus_port_hresp)
    else $error("read wait state sequence wrong");
  a_err_resp: assert property (apValid && !apMapped |=> host_bus_port_hresp && !host_bus_port_hreadyout ##1 host_bus_port_hresp && host_bus_port_hreadyout)
    else $error("error response sequence wrong");
  a_int_reset: assert property (disable iff (1'b0) !rst_n |=> !intReq)
    else $error("interrupt not low after reset");
  c_master_done: cover property (mStateQ == M_STOP ##1 mStateQ == M_IDLE);
  c_slave_read: cover property (sStateQ == S_TXACK && sclFall && sFlagQ);
  c_host_error: cover property (apValid && !apMapped);
  c_arb_lost: cover property (mLose);
endmodule : smb_mailbox_top

// File: smb_peer.sv
// External SMBus master model on the shared open-drain lines
`timescale 1ns/10ps
module smb_peer (
  output logic sclPull,
  output logic sdaPull,
  input wire logic sda
);
  // ********
  // Framing
  // ********
  initial begin
    sclPull = 0;
    sdaPull = 0;
  end
  task automatic start;
    sdaPull = 0;
    #31 sclPull = 0;
    #62 sdaPull = 1;
    #62 sclPull = 1;
    #31;
  endtask : start
  task automatic stop;
    sdaPull = 1;
    #31 sclPull = 0;
    #62 sdaPull = 0;
    #62;
  endtask : stop
  // One bit per 125 ns link period, sampled while the clock line is high
  task automatic bitx(input logic b, output logic r);
    sdaPull = !b;
    #31 sclPull = 0;
    #62 r = sda;
    sclPull = 1;
    #32;
  endtask : bitx
  // A competing master holding the data line low
  task automatic hold(input logic b);
    sdaPull = b;
  endtask : hold
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
    ack = !a;
  endtask : xb
endmodule : smb_peer

// File: smb_mailbox_top_bench.sv
// Self-checking bench for the SMBus mailbox
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module smb_mailbox_top_bench
  import smb_pkg::*;
;
  logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hrdyo, hresp, intReq, sclOe, sdaOe, sclO, sdaO, alertN, rsp, ack;
  logic [7:0] q;
  wire logic scl, sda, sclP, sdaP;
  int mismatches = 0, n_tests = 0;
  assign scl = !(sclOe | sclP);
  assign sda = !(sdaOe | sdaP);
  smb_mailbox_top #(.QTR_CYC(4), .FREE_CYC(8)) smb_mailbox_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .host_bus_port_hsel(hsel),
    .host_bus_port_haddr(haddr), .host_bus_port_hburst(3'h0),
    .host_bus_port_hsize(3'h2), .host_bus_port_htrans(htrans),
    .host_bus_port_hwdata(hwdata), .host_bus_port_hwrite(hwrite),
    .host_bus_port_hready(hrdyo),
    .host_bus_port_hreadyout(hrdyo), .host_bus_port_hresp(hresp),
    .host_bus_port_hrdata(hrdata), .intReq(intReq), .scl_i(scl), .scl_o(sclO),
    .scl_oe(sclOe), .sda_i(sda), .sda_o(sdaO), .sda_oe(sdaOe), .smbAlert_n(alertN));
  smb_peer smb_peer_i (.sclPull(sclP), .sdaPull(sdaP), .sda(sda));
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #400000;
    mismatches++;
    results();
  end
  task automatic results;
    $display("Compares %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // ********
  // Host bus helpers
  // ********
  task automatic ahb(input logic [1:0] tr, input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    hsel <= 1;
    htrans <= tr;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge clk_sys);
    hsel <= 0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    k = 0;
    #1;
    while (hrdyo !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    rd = hrdata;
    rsp = hresp;
    if (k == 20) begin
      mismatches++;
      results();
    end
  endtask : ahb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(HTRANS_NONSEQ, 1'b1, a, d);
  endtask : wr
  task automatic rdx(input logic [11:0] a);
    ahb(HTRANS_NONSEQ, 1'b0, a, 32'h0);
  endtask : rdx
  task automatic smbRead(input logic [6:0] a, input logic [7:0] c);
    smb_peer_i.start();
    smb_peer_i.xb({a, 1'b0}, q, ack);
    smb_peer_i.xb(c, q, ack);
    smb_peer_i.start();
    smb_peer_i.xb({a, 1'b1}, q, ack);
    smb_peer_i.xb(8'hFF, q, ack);
    smb_peer_i.stop();
  endtask : smbRead
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rdx(OFS_SLV_ADDR);
    `CHK(rd[6:0], SLV_ADDR_RST)
    `CHK(rsp, 1'b0)
    ahb(HTRANS_BUSY, 1'b1, OFS_SLV_ADDR, 32'h33);
    ahb(HTRANS_SEQ, 1'b0, OFS_SLV_ADDR, 32'h0);
    `CHK(rd[6:0], SLV_ADDR_RST)
    ahb(HTRANS_SEQ, 1'b1, OFS_SLV_ADDR, 32'h33);
    rdx(OFS_SLV_ADDR);
    `CHK(rd[6:0], 7'h33)
    rdx(12'h800);
    `CHK(rsp, 1'b1)
    wr(OFS_CONTROL, 32'h40);
    rdx(OFS_CONTROL);
    `CHK(alertN, 1'b0)
  endtask : t_regs
  task automatic t_rbyte;
    wr(OFS_REGFILE + 12'hC, 32'hC3);
    wr(OFS_CONTROL, 32'h20);
    smbRead(7'h61, 8'h03);
    `CHK(q, 8'hC3)
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_DATA, 32'h77);
    smbRead(7'h61, 8'h03);
    `CHK(q, 8'h77)
    rdx(OFS_DATA);
    `CHK(rd[7:0], 8'h03)
    rdx(OFS_DATA);
    `CHK(rd[7:0], 8'h03)
  endtask : t_rbyte
  task automatic t_wbyte;
    smb_peer_i.start();
    smb_peer_i.xb({7'h2A, 1'b0}, q, ack);
    `CHK(ack, 1'b0)
    smb_peer_i.stop();
    smb_peer_i.start();
    smb_peer_i.xb({7'h33, 1'b0}, q, ack);
    `CHK(ack, 1'b1)
    smb_peer_i.xb(8'h03, q, ack);
    smb_peer_i.xb(8'h5A, q, ack);
    `CHK(ack, 1'b1)
    smb_peer_i.stop();
    `CHK(intReq, 1'b1)
    rdx(OFS_DATA);
    `CHK(rd[7:0], 8'h03)
    rdx(OFS_DATA);
    `CHK(rd[7:0], 8'h5A)
    rdx(OFS_REGFILE + 12'hC);
    `CHK(rd[7:0], 8'hC3)
  endtask : t_wbyte
  task automatic mstGo;
    int k;
    wr(OFS_MST_CTRL, {1'b1, 7'h0, 8'h05, 8'h0F, 1'b0, 7'h10});
    k = 0;
    while (sdaOe !== 1'b1 && k < 300) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (sdaOe !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask : mstGo
  task automatic mstWait;
    int k;
    k = 0;
    do begin
      rdx(OFS_STATUS);
      k++;
    end while (rd[ST_MDONE_BIT] !== 1'b1 && k < 2000);
    if (rd[ST_MDONE_BIT] !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask : mstWait
  task automatic t_master;
    mstGo();
    `CHK(scl, 1'b1)
    mstWait();
    `CHK(rd[ST_NACK_BIT], 1'b1)
  endtask : t_master
  // Another master keeps data low for 500 cycles, past the first address bit that ours leaves high
  task automatic t_arb;
    mstGo();
    smb_peer_i.hold(1'b1);
    repeat (500) @(posedge clk_sys);
    smb_peer_i.hold(1'b0);
    mstWait();
    `CHK(rd[ST_ARBLOST_BIT], 1'b1)
    `CHK(rd[ST_NACK_BIT], 1'b1)
  endtask : t_arb
  initial begin
    repeat (5) @(posedge clk_sys);
    `CHK({hrdyo, hresp, intReq, alertN, sclOe, sdaOe}, 6'b100100)
    `CHK({sclO, sdaO, hrdata}, 34'h0)
    @(posedge clk_sys);
    rst_n <= 1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_rbyte();
    t_wbyte();
    t_master();
    t_arb();
    results();
  end
endmodule : smb_mailbox_top_bench
